// ===== rtl/backlight_control_regs.sv
`timescale 1ns/100ps
`include "backlight_regs_defs.svh"


module backlight_control_regs #(
    parameter logic [15:0] MEM_WAIT = `MEM_OP_WAIT
) (
    // Clock, reset, enable
    input  wire logic                         clk_in,
    input  wire logic                         resetn_in,
    input  wire logic                         ce_in,
    // Register access from the serial control port
    input  wire backlight_regs_pkg::reg_req_t reg_req_in,
    output logic [7:0]                        rd_data_out,
    output logic                              rd_valid_out,
    // Converter result
    input  wire logic [11:0]                  adc_result_in,
    input  wire logic                         adc_valid_in,
    // Boost and operating controls
    output logic [4:0]                        boost_code_out,
    output logic                              boost_code_valid_out,
    output backlight_regs_pkg::ctrl_fields_t  ctrl_out,
    // Brightness multipliers
    output logic [7:0]                        mult_red_out,
    output logic [7:0]                        mult_green_out,
    output logic [7:0]                        mult_blue_out,
    // Calibration memory status
    output logic                              memory_idle_flag_out
);

    logic [4:0]  boost_r;
    logic [11:0] result_r;
    logic [1:0]  memory_page_select_r;
    logic [7:0]  wc_r [0:31];
    logic [7:0]  rd_nxt;
    logic [7:0]  rd_addr_r;
    logic        wr_ok;
    logic        start_req;
    logic        mem_busy;
    logic        eng_wc_wr;
    logic [4:0]  eng_wc_rd_idx;
    logic [4:0]  eng_wc_wr_idx;
    logic [7:0]  eng_wc_wr_data;
    backlight_regs_pkg::mem_op_t start_op;
    backlight_regs_pkg::mem_op_t run_op;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = reg_req_in.wr && a == target;
    endfunction : hit

    function automatic logic in_wc(input logic [7:0] a);
        in_wc = a >= `ADDR_WC_FIRST && a <= `ADDR_WC_LAST;
    endfunction : in_wc

    assign wr_ok = ce_in && reg_req_in.wr;

    // Boost code register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            boost_r <= `BOOST_RESET;
        end else if (ce_in && hit(reg_req_in.addr, `ADDR_BOOST)) begin
            boost_r <= reg_req_in.wdata[4:0];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            boost_code_out       <= `BOOST_RESET;
            boost_code_valid_out <= 1'b0;
        end else if (ce_in) begin
            boost_code_out       <= boost_r;
            boost_code_valid_out <= boost_r >= `BOOST_CODE_MIN
                                    && boost_r <= `BOOST_CODE_MAX;
        end
    end

    // Operating control register; the fields drive the boost, loader and mode pins directly
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_out <= `CTRL_RESET;
        end else if (ce_in && hit(reg_req_in.addr, `ADDR_CTRL)) begin
            ctrl_out <= reg_req_in.wdata[5:0];
        end
    end

    // Converter result, captured on each valid strobe
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            result_r <= `RES_RESET;
        end else if (ce_in && adc_valid_in) begin
            result_r <= adc_result_in;
        end
    end

    // Brightness multipliers, code over 128
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mult_red_out   <= `MULT_RESET;
            mult_green_out <= `MULT_RESET;
            mult_blue_out  <= `MULT_RESET;
        end else if (ce_in) begin
            if (hit(reg_req_in.addr, `ADDR_MULT_R)) begin
                mult_red_out <= reg_req_in.wdata;
            end
            if (hit(reg_req_in.addr, `ADDR_MULT_G)) begin
                mult_green_out <= reg_req_in.wdata;
            end
            if (hit(reg_req_in.addr, `ADDR_MULT_B)) begin
                mult_blue_out <= reg_req_in.wdata;
            end
        end
    end

    // Memory control: erase wins over program, program over load
    always_comb begin
        start_op = backlight_regs_pkg::OP_NONE;
        if (reg_req_in.wdata[`MEMCTL_ERASE_BIT]) begin
            start_op = backlight_regs_pkg::OP_ERASE;
        end else if (reg_req_in.wdata[`MEMCTL_PROG_BIT]) begin
            start_op = backlight_regs_pkg::OP_PROG;
        end else if (reg_req_in.wdata[`MEMCTL_LOAD_BIT]) begin
            start_op = backlight_regs_pkg::OP_LOAD;
        end
    end

    // Control writes during an operation are dropped so the page cannot move under it
    assign start_req = wr_ok && !mem_busy && reg_req_in.addr == `ADDR_MEMCTL;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            memory_page_select_r <= `PAGE_RESET;
        end else if (start_req) begin
            memory_page_select_r <= reg_req_in.wdata[1:0];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            memory_idle_flag_out <= 1'b1;
        end else if (ce_in) begin
            memory_idle_flag_out <= !mem_busy && !(start_req && start_op != backlight_regs_pkg::OP_NONE);
        end
    end

    cal_memory_engine #(
        .OP_WAIT (MEM_WAIT)
    ) u_engine (
        .clk_in         (clk_in),
        .resetn_in      (resetn_in),
        .ce_in          (ce_in),
        .start_in       (start_req),
        .op_in          (start_op),
        .page_in        (reg_req_in.wdata[1:0]),
        .wc_rd_data_in  (wc_r[eng_wc_rd_idx]),
        .wc_idx_out     (eng_wc_rd_idx),
        .wc_wr_out      (eng_wc_wr),
        .wc_wr_idx_out  (eng_wc_wr_idx),
        .wc_wr_data_out (eng_wc_wr_data),
        .busy_out       (mem_busy),
        .op_out         (run_op)
    );

    // Working copy; host writes are ignored while an operation runs
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 32; i++) begin
                wc_r[i] <= `ERASED_BYTE;
            end
        end else if (ce_in) begin
            if (eng_wc_wr) begin
                wc_r[eng_wc_wr_idx] <= eng_wc_wr_data;
            end else if (reg_req_in.wr && !mem_busy && in_wc(reg_req_in.addr)) begin
                wc_r[reg_req_in.addr[4:0]] <= reg_req_in.wdata;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_nxt = 8'h00;
        unique case (reg_req_in.addr)
            `ADDR_BOOST:  rd_nxt = {3'h0, boost_r};
            `ADDR_CTRL:   rd_nxt = {2'h0, ctrl_out};
            `ADDR_RES_HI: rd_nxt = {4'h0, result_r[11:8]};
            `ADDR_RES_LO: rd_nxt = result_r[7:0];
            `ADDR_MULT_R: rd_nxt = mult_red_out;
            `ADDR_MULT_G: rd_nxt = mult_green_out;
            `ADDR_MULT_B: rd_nxt = mult_blue_out;
            `ADDR_MEMCTL: begin
                rd_nxt[`MEMCTL_IDLE_BIT]  = !mem_busy;
                rd_nxt[`MEMCTL_ERASE_BIT] = run_op == backlight_regs_pkg::OP_ERASE;
                rd_nxt[`MEMCTL_PROG_BIT]  = run_op == backlight_regs_pkg::OP_PROG;
                rd_nxt[`MEMCTL_LOAD_BIT]  = run_op == backlight_regs_pkg::OP_LOAD;
                rd_nxt[1:0]               = memory_page_select_r;
            end
            default: begin
                if (in_wc(reg_req_in.addr)) begin
                    rd_nxt = wc_r[reg_req_in.addr[4:0]];
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
            rd_addr_r    <= 8'h00;
        end else if (ce_in) begin
            rd_valid_out <= reg_req_in.rd;
            if (reg_req_in.rd) begin
                rd_data_out <= rd_nxt;
                rd_addr_r   <= reg_req_in.addr;
            end
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    a_boost_upper_zero: assert property (
        rd_valid_out && rd_addr_r == `ADDR_BOOST |-> rd_data_out[7:5] == 3'h0)
        else $error("boost register upper bits not zero");

    a_ctrl_read_back: assert property (
        ce_in && hit(reg_req_in.addr, `ADDR_CTRL) && !reg_req_in.rd
        ##1 !reg_req_in.wr
        ##1 ce_in && reg_req_in.rd && reg_req_in.addr == `ADDR_CTRL && !reg_req_in.wr
        |=> rd_data_out == {2'h0, $past(reg_req_in.wdata[5:0], 3)})
        else $error("control register read back wrong");

    a_result_hi_map: assert property (
        ce_in && reg_req_in.rd && reg_req_in.addr == `ADDR_RES_HI
        |=> rd_data_out == {4'h0, $past(result_r[11:8])})
        else $error("result high register wrong");

    a_result_low_map: assert property (
        ce_in && adc_valid_in ##1 ce_in && reg_req_in.rd && reg_req_in.addr == `ADDR_RES_LO && !adc_valid_in
        |=> rd_data_out == $past(adc_result_in[7:0], 2))
        else $error("result low register wrong");

    a_mult_red_write: assert property (
        ce_in && hit(reg_req_in.addr, `ADDR_MULT_R) |=> mult_red_out == $past(reg_req_in.wdata))
        else $error("red multiplier not written");

    a_boost_valid_flag: assert property (
        ce_in && hit(reg_req_in.addr, `ADDR_BOOST) ##1 ce_in
        |=> boost_code_valid_out == ($past(reg_req_in.wdata[4:0], 2) inside {[5'h05:5'h14]}))
        else $error("boost code range flag wrong");

    a_start_sets_busy: assert property (
        start_req && start_op != backlight_regs_pkg::OP_NONE |=> !memory_idle_flag_out && mem_busy)
        else $error("memory operation did not start");

    a_page_held_busy: assert property (
        mem_busy && ce_in |=> $stable(memory_page_select_r))
        else $error("page select moved during operation");

    a_idle_flag_read: assert property (
        ce_in && reg_req_in.rd && reg_req_in.addr == `ADDR_MEMCTL
        |=> rd_data_out[`MEMCTL_IDLE_BIT] == $past(!mem_busy))
        else $error("ready flag read wrong");

    a_wc_guard_busy: assert property (
        mem_busy && ce_in && reg_req_in.wr && in_wc(reg_req_in.addr) && !eng_wc_wr
        |=> wc_r[$past(reg_req_in.addr[4:0])] == $past(wc_r[reg_req_in.addr[4:0]]))
        else $error("working copy written during operation");

    a_ctrl_write_land: assert property (
        ce_in && hit(reg_req_in.addr, `ADDR_CTRL) |=> ctrl_out == $past(reg_req_in.wdata[5:0]))
        else $error("control fields not written");

    a_ctrl_upper_zero: assert property (
        ce_in && reg_req_in.rd && reg_req_in.addr == `ADDR_CTRL
        |=> rd_data_out[7:6] == 2'h0)
        else $error("control register upper bits not zero");

    a_boost_code_follow: assert property (
        ce_in && hit(reg_req_in.addr, `ADDR_BOOST) ##1 ce_in
        |=> boost_code_out == $past(reg_req_in.wdata[4:0], 2))
        else $error("boost code output wrong");

    a_mult_red_read: assert property (
        ce_in && reg_req_in.rd && reg_req_in.addr == `ADDR_MULT_R
        |=> rd_data_out == $past(mult_red_out))
        else $error("red multiplier read wrong");

    a_mult_green_write: assert property (
        ce_in && hit(reg_req_in.addr, `ADDR_MULT_G) |=> mult_green_out == $past(reg_req_in.wdata))
        else $error("green multiplier not written");

    a_mult_blue_write: assert property (
        ce_in && hit(reg_req_in.addr, `ADDR_MULT_B) |=> mult_blue_out == $past(reg_req_in.wdata))
        else $error("blue multiplier not written");

    a_result_capture: assert property (
        ce_in && adc_valid_in |=> result_r == $past(adc_result_in))
        else $error("converter result not captured");

    a_page_on_start: assert property (
        start_req |=> memory_page_select_r == $past(reg_req_in.wdata[1:0]))
        else $error("page select not taken");

    a_page_read_back: assert property (
        ce_in && reg_req_in.rd && reg_req_in.addr == `ADDR_MEMCTL
        |=> rd_data_out[1:0] == $past(memory_page_select_r))
        else $error("page select read wrong");

    a_idle_while_busy: assert property (
        mem_busy |-> !memory_idle_flag_out)
        else $error("ready flag high during operation");

    a_op_held_busy: assert property (
        mem_busy && ce_in |=> !mem_busy || $stable(run_op))
        else $error("operation changed while running");

    a_wc_host_write: assert property (
        ce_in && reg_req_in.wr && !mem_busy && in_wc(reg_req_in.addr)
        |=> wc_r[$past(reg_req_in.addr[4:0])] == $past(reg_req_in.wdata))
        else $error("working copy write lost");

    a_load_fills_copy: assert property (
        ce_in && eng_wc_wr |=> wc_r[$past(eng_wc_wr_idx)] == $past(eng_wc_wr_data))
        else $error("loaded byte not stored");

    a_wc_read_map: assert property (
        ce_in && reg_req_in.rd && in_wc(reg_req_in.addr)
        |=> rd_data_out == $past(wc_r[reg_req_in.addr[4:0]]))
        else $error("working copy read wrong");

endmodule : backlight_control_regs

// ===== rtl/backlight_regs_defs.svh
`ifndef BACKLIGHT_REGS_DEFS_SVH
`define BACKLIGHT_REGS_DEFS_SVH

// Register offsets
`define ADDR_BOOST      8'h05
`define ADDR_CTRL       8'h06
`define ADDR_RES_HI     8'h08
`define ADDR_RES_LO     8'h09
`define ADDR_MULT_R     8'h0a
`define ADDR_MULT_G     8'h0b
`define ADDR_MULT_B     8'h0c
`define ADDR_MEMCTL     8'h0d
`define ADDR_WC_FIRST   8'h40
`define ADDR_WC_LAST    8'h5f

// Reset values
`define BOOST_RESET     5'h00
`define CTRL_RESET      6'h04
`define MULT_RESET      8'h80
`define RES_RESET       12'h000
`define PAGE_RESET      2'h0
`define ERASED_BYTE     8'hff

// Field positions of the memory control register
`define MEMCTL_IDLE_BIT  7
`define MEMCTL_ERASE_BIT 6
`define MEMCTL_PROG_BIT  5
`define MEMCTL_LOAD_BIT  4

// Valid boost code range, 5 V to 20 V
`define BOOST_CODE_MIN  5'h05
`define BOOST_CODE_MAX  5'h14

// Settle cycles after the last byte of a memory operation
`define MEM_OP_WAIT     16'h0010

`endif

// ===== rtl/backlight_regs_pkg.sv
package backlight_regs_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic sensor_source_select;
        logic comp_input_select;
        logic loader_en;
        logic adaptive_boost;
        logic boost_en;
        logic active;
    } ctrl_fields_t;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_ERASE,
        OP_PROG,
        OP_LOAD
    } mem_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XFER,
        ST_SETTLE
    } eng_state_t;

endpackage : backlight_regs_pkg

// ===== rtl/cal_memory_engine.sv
`timescale 1ns/100ps
`include "backlight_regs_defs.svh"

module cal_memory_engine #(
    parameter logic [15:0] OP_WAIT = `MEM_OP_WAIT
) (
    // Clock, reset and enable
    input  wire logic                        clk_in,
    input  wire logic                        resetn_in,
    input  wire logic                        ce_in,
    // Operation request
    input  wire logic                        start_in,
    input  wire backlight_regs_pkg::mem_op_t op_in,
    input  wire logic [1:0]                  page_in,
    // Working copy access
    input  wire logic [7:0]                  wc_rd_data_in,
    output logic [4:0]                       wc_idx_out,
    output logic                             wc_wr_out,
    output logic [4:0]                       wc_wr_idx_out,
    output logic [7:0]                       wc_wr_data_out,
    // Status
    output logic                             busy_out,
    output backlight_regs_pkg::mem_op_t      op_out
);

    backlight_regs_pkg::eng_state_t state_r;
    logic [7:0]  nvm_r [0:127];
    logic [1:0]  page_r;
    logic [15:0] wait_r;
    logic [6:0]  addr;

    assign addr = {page_r, wc_idx_out};

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r    <= backlight_regs_pkg::ST_IDLE;
            op_out     <= backlight_regs_pkg::OP_NONE;
            page_r     <= `PAGE_RESET;
            wc_idx_out <= 5'h00;
            wait_r     <= 16'h0000;
        end else if (ce_in) begin
            unique case (state_r)
                backlight_regs_pkg::ST_IDLE: begin
                    if (start_in && op_in != backlight_regs_pkg::OP_NONE) begin
                        state_r    <= backlight_regs_pkg::ST_XFER;
                        op_out     <= op_in;
                        page_r     <= page_in;
                        wc_idx_out <= 5'h00;
                    end
                end
                backlight_regs_pkg::ST_XFER: begin
                    wc_idx_out <= wc_idx_out + 5'h01;
                    if (wc_idx_out == 5'h1f) begin
                        state_r <= backlight_regs_pkg::ST_SETTLE;
                        wait_r  <= OP_WAIT;
                    end
                end
                backlight_regs_pkg::ST_SETTLE: begin
                    wait_r <= wait_r - 16'h0001;
                    if (wait_r <= 16'h0001) begin
                        state_r <= backlight_regs_pkg::ST_IDLE;
                        op_out  <= backlight_regs_pkg::OP_NONE;
                    end
                end
            endcase
        end
    end

    // One byte per cycle over the selected page
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 128; i++) begin
                nvm_r[i] <= `ERASED_BYTE;
            end
        end else if (ce_in && state_r == backlight_regs_pkg::ST_XFER) begin
            if (op_out == backlight_regs_pkg::OP_ERASE) begin
                nvm_r[addr] <= `ERASED_BYTE;
            end else if (op_out == backlight_regs_pkg::OP_PROG) begin
                nvm_r[addr] <= wc_rd_data_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wc_wr_out      <= 1'b0;
            wc_wr_idx_out  <= 5'h00;
            wc_wr_data_out <= 8'h00;
        end else if (ce_in) begin
            wc_wr_out      <= state_r == backlight_regs_pkg::ST_XFER
                              && op_out == backlight_regs_pkg::OP_LOAD;
            wc_wr_idx_out  <= wc_idx_out;
            wc_wr_data_out <= nvm_r[addr];
        end
    end

    // A zero settle count still spends one cycle settling
    localparam int DONE_AT = 33 + ((OP_WAIT == 16'h0000) ? 1 : int'(OP_WAIT));

    assign busy_out = state_r != backlight_regs_pkg::ST_IDLE;

    a_busy_min_span: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && !busy_out && start_in && op_in != backlight_regs_pkg::OP_NONE)
        |=> busy_out [*8])
        else $error("memory operation ended too early");

    a_busy_bounded: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && !busy_out && start_in && op_in != backlight_regs_pkg::OP_NONE)
        |-> ##DONE_AT !busy_out)
        else $error("memory operation did not finish in time");

endmodule : cal_memory_engine

// ===== test/host_port_model.sv
`timescale 1ns/100ps
`include "backlight_regs_defs.svh"

module host_port_model (
    // Clock and read answer
    input  wire logic                    clk_in,
    input  wire logic [7:0]              rd_data_in,
    input  wire logic                    rd_valid_in,
    // Request to the register port
    output backlight_regs_pkg::reg_req_t reg_req_out
);
    initial reg_req_out = '0;

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_req_out <= '{1'b1, 1'b0, a, d};
        @(posedge clk_in);
        reg_req_out <= '0;
    endtask : write_reg

    // Answer is a one-cycle pulse, so it is sampled just after the taking edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_in);
        reg_req_out <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_in);
        reg_req_out <= '0;
        #1;
        v = rd_valid_in;
        d = rd_data_in;
    endtask : read_reg

    task automatic wait_idle(output logic ok);
        logic [7:0] d;
        logic       v;
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            read_reg(`ADDR_MEMCTL, d, v);
            ok = (v === 1'b1) && (d[7] === 1'b1);
        end
    endtask : wait_idle

    // One operation at a time: wait for the idle flag, then start even if wait_idle gave up without seeing it
    task automatic start_op(input logic [7:0] cmd, output logic ok);
        wait_idle(ok);
        write_reg(`ADDR_MEMCTL, cmd);
    endtask : start_op
endmodule : host_port_model

// ===== test/tb.sv
`timescale 1ns/100ps
`include "backlight_regs_defs.svh"

module tb;
    localparam int         LIMIT        = 5000;
    localparam logic [7:0] RST_A [8]    = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
    localparam logic [7:0] RST_V [8]    = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80};
    localparam logic [4:0] CODES [5]    = '{5'h04, 5'h05, 5'h14, 5'h15, 5'h1f};
    localparam logic [7:0] MVALS [3]    = '{8'h00, 8'hff, 8'h55};

    logic                             clk_in = 1'b0;
    logic                             resetn_in;
    logic                             ce_in;
    backlight_regs_pkg::reg_req_t     reg_req;
    logic [7:0]                       rd_data;
    logic                             rd_valid;
    logic [11:0]                      adc_result;
    logic                             adc_valid;
    logic [4:0]                       boost_code;
    logic                             boost_code_valid;
    backlight_regs_pkg::ctrl_fields_t ctrl;
    logic [7:0]                       mult [3];
    logic                             idle_flag;
    int                               err_count = 0;
    int                               n_checks  = 0;
    int                               cycles    = 0;
    logic                             ok;

    always #5 clk_in = ~clk_in;

    backlight_control_regs #(.MEM_WAIT(16'h0004)) uut (
        .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .reg_req_in(reg_req),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid), .adc_result_in(adc_result),
        .adc_valid_in(adc_valid), .boost_code_out(boost_code), .boost_code_valid_out(boost_code_valid),
        .ctrl_out(ctrl), .mult_red_out(mult[0]), .mult_green_out(mult[1]), .mult_blue_out(mult[2]),
        .memory_idle_flag_out(idle_flag)
    );

    host_port_model host (
        .clk_in(clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid), .reg_req_out(reg_req)
    );

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        host.read_reg(a, d, v);
        n_checks++;
        if (v !== 1'b1 || d !== exp) begin
            err_count++;
            $display("Error reg %h expected %h seen %h valid %b", a, exp, d, v);
        end
    endtask : chk_reg

    task automatic chk_out(input string nm, input logic [11:0] exp, input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_out

    task automatic mem_cmd(input logic [7:0] cmd);
        host.start_op(cmd, ok);
        chk_out("idle before start", 12'h001, {11'h0, ok});
    endtask : mem_cmd

    task automatic idle_wait;
        host.wait_idle(ok);
        chk_out("idle reached", 12'h001, {11'h0, ok});
    endtask : idle_wait

    // Working copy holds either the test pattern or erased bytes
    task automatic chk_wc(input logic erased);
        for (int i = 0; i < 32; i++) begin
            chk_reg(8'h40 + 8'(i), erased ? 8'hff : (8'(i) ^ 8'ha5));
        end
    endtask : chk_wc

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        resetn_in  = 1'b0;
        ce_in      = 1'b1;
        adc_result = 12'h000;
        adc_valid  = 1'b0;
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1;
        chk_out("ctrl_out", 12'h004, {6'h0, ctrl});
        chk_out("idle flag", 12'h001, {11'h0, idle_flag});
        for (int i = 0; i < 3; i++) chk_out("mult", 12'h080, {4'h0, mult[i]});
        for (int i = 0; i < 8; i++) chk_reg(RST_A[i], RST_V[i]);

        foreach (CODES[i]) begin
            host.write_reg(`ADDR_BOOST, {3'b111, CODES[i]});
            chk_reg(`ADDR_BOOST, {3'b000, CODES[i]});
            chk_out("boost code", {7'h0, CODES[i]}, {7'h0, boost_code});
            chk_out("boost valid", {11'h0, CODES[i] >= 5'h05 && CODES[i] <= 5'h14},
                    {11'h0, boost_code_valid});
        end

        for (int i = 0; i < 8; i++) begin
            host.write_reg(`ADDR_CTRL, 8'h01 << i);
            chk_reg(`ADDR_CTRL, (8'h01 << i) & 8'h3f);
            chk_out("ctrl_out", {6'h0, 6'((8'h01 << i) & 8'h3f)}, {6'h0, ctrl});
        end

        for (int c = 0; c < 3; c++) begin
            foreach (MVALS[k]) begin
                host.write_reg(`ADDR_MULT_R + 8'(c), MVALS[k]);
                chk_reg(`ADDR_MULT_R + 8'(c), MVALS[k]);
                chk_out("mult", {4'h0, MVALS[k]}, {4'h0, mult[c]});
            end
        end

        // Enable low freezes the bank: this write must not land
        @(posedge clk_in);
        ce_in <= 1'b0;
        host.write_reg(`ADDR_MULT_R, 8'h3c);
        ce_in <= 1'b1;
        chk_reg(`ADDR_MULT_R, 8'h55);

        // Result must be captured on the strobe, not followed afterwards
        @(posedge clk_in);
        adc_result <= 12'habc;
        adc_valid  <= 1'b1;
        fork
            chk_reg(`ADDR_RES_LO, 8'hbc);
            begin
                @(posedge clk_in);
                adc_result <= 12'h123;
                adc_valid  <= 1'b0;
            end
        join
        host.write_reg(`ADDR_RES_HI, 8'hff);
        host.write_reg(`ADDR_RES_LO, 8'h00);
        chk_reg(`ADDR_RES_HI, 8'h0a);
        chk_reg(`ADDR_RES_LO, 8'hbc);
        host.write_reg(8'h07, 8'hff);
        chk_reg(8'h07, 8'h00);

        for (int i = 0; i < 32; i++) host.write_reg(8'h40 + 8'(i), 8'(i) ^ 8'ha5);
        mem_cmd(8'h22);
        #1;
        chk_out("idle flag", 12'h000, {11'h0, idle_flag});
        chk_reg(`ADDR_MEMCTL, 8'h22);
        host.write_reg(`ADDR_MEMCTL, 8'h41);
        host.write_reg(8'h40, 8'h00);
        idle_wait();
        chk_reg(`ADDR_MEMCTL, 8'h82);
        chk_reg(8'h40, 8'ha5);
        mem_cmd(8'h11);
        idle_wait();
        chk_wc(1'b1);
        mem_cmd(8'h12);
        idle_wait();
        chk_wc(1'b0);
        mem_cmd(8'h42);
        mem_cmd(8'h12);
        idle_wait();
        chk_wc(1'b1);
        wrap_up();
    end
endmodule : tb
